// *** hdl/rtb_pkg.sv ***
package rtb_pkg;

	localparam int NUM_TIMERS = 46;
	localparam int T_MSD      = 0;
	localparam int T_CTS      = 3;
	localparam int T_HANG     = 6;
	localparam int T_MUTE     = 9;
	localparam int T_POLL     = 12;
	localparam int T_RES      = 13;
	localparam int T_IMP      = 26;
	localparam int T_INIT     = 28;
	localparam int T_PEND     = 30;
	localparam int T_TOUT     = 32;
	localparam int T_PTONE    = 35;
	localparam int T_PWIN     = 38;
	localparam int T_USER     = 41;
	localparam int T_LAST     = 45;

	localparam logic [45:0] SHORT_MASK = 46'h0000_0000_1FFF;
	localparam logic [45:0] RES_MASK   = 46'h0000_03FF_E000;
	localparam logic [45:0] LONG_MASK  = 46'h3FFF_FC00_0000;
	localparam logic [45:0] POLL_MASK  = 46'h0000_0000_1000;

	localparam int          CLK_PERIOD_NS  = 25;
	localparam int          SHORT_TICK_NS  = 10_000_000;
	localparam int unsigned SHORT_TICK_CYC = SHORT_TICK_NS / CLK_PERIOD_NS;
	localparam logic [6:0]  SHORT_PER_LONG = 7'h64;

	localparam logic [7:0] ADDR_CMD    = 8'h00;
	localparam logic [7:0] ADDR_RESP   = 8'h04;
	localparam logic [7:0] ADDR_STAT   = 8'h08;
	localparam logic [7:0] ADDR_RUN_LO = 8'h0C;
	localparam logic [7:0] ADDR_RUN_HI = 8'h10;
	localparam int         STAT_VALID  = 0;
	localparam int         STAT_BUSY   = 1;
	localparam int         STAT_ERR    = 2;

	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_RECALL  = 4'h2;
	localparam logic [3:0] OP_RESTART = 4'h3;
	localparam logic [3:0] OP_CANCEL  = 4'h4;
	localparam logic [7:0] SEP_IS     = 8'hA5;
	localparam logic [7:0] SEP_ACK    = 8'h5A;
	localparam logic [6:0] MAX_NUM    = 7'h2D;

	localparam logic [15:0] DEF_MSD   = 16'h0050;
	localparam logic [15:0] DEF_CTS   = 16'h0100;
	localparam logic [15:0] DEF_HANG  = 16'h0001;
	localparam logic [15:0] DEF_MUTE  = 16'h0100;
	localparam logic [15:0] DEF_POLL  = 16'h0100;
	localparam logic [15:0] DEF_RES   = 16'h0000;
	localparam logic [15:0] DEF_IMP   = 16'h0020;
	localparam logic [15:0] DEF_INIT  = 16'h0600;
	localparam logic [15:0] DEF_PEND  = 16'h0540;
	localparam logic [15:0] DEF_TOUT  = 16'h0180;
	localparam logic [15:0] DEF_PTONE = 16'h0008;
	localparam logic [15:0] DEF_PWIN  = 16'h0008;
	localparam logic [15:0] DEF_USER  = 16'h0010;

	typedef logic [NUM_TIMERS-1:0][15:0] rtb_table_type;

	typedef enum logic [1:0] {
		CMD_IDLE   = 2'b01,
		CMD_RECALL = 2'b10
	} rtb_cmd_state_type;

	typedef struct packed {
		logic [3:0]  op;
		logic [7:0]  num;
		logic [3:0]  unused;
		logic [15:0] value;
	} rtb_cmd_type;

	typedef struct packed {
		logic [7:0]  num;
		logic [7:0]  sep;
		logic [15:0] value;
	} rtb_resp_type;

	typedef struct packed {
		logic [2:0] carrier_detect_input;
		logic [2:0] digit_active;
		logic [2:0] preaccess_start;
	} rtb_port_in_type;

	typedef struct packed {
		logic [2:0] transmitter_key_line;
		logic [2:0] tone_hold;
		logic [2:0] courtesy_send;
		logic [2:0] rx_mute;
		logic [2:0] rx_disabled;
		logic [2:0] timeout_event;
		logic [2:0] timeout_clear_event;
		logic [2:0] preaccess_tone;
		logic [2:0] access_lost;
		logic       io_poll_strobe;
		logic [1:0] id_impolite;
		logic [1:0] id_initial;
		logic [1:0] id_pending;
		logic [4:0] user_macro;
	} rtb_port_out_type;

	typedef struct packed {
		rtb_cmd_state_type             cstate;
		logic [5:0]                    scan;
		logic [5:0]                    scan_q;
		logic [NUM_TIMERS-1:0][13:0]   count;
		logic [NUM_TIMERS-1:0]         run;
		logic [NUM_TIMERS-1:0]         start_pend;
		logic [NUM_TIMERS-1:0]         tick_pend;
		logic [NUM_TIMERS-1:0]         exp;
		logic [2:0]                    prev_carrier;
		logic [2:0]                    prev_digit;
		logic [2:0]                    msd_done;
		logic [2:0]                    cts_pend;
		logic [2:0]                    timed_out;
		logic [5:0]                    target;
		rtb_resp_type                  resp;
		logic                          resp_valid;
		logic                          err;
		logic [31:0]                   prdata;
		rtb_port_out_type              out;
	} rtb_state_type;

	typedef struct packed {
		rtb_table_type mem;
		logic [15:0]   rdata;
	} rtb_mem_state_type;

	typedef struct packed {
		logic [23:0] cnt;
		logic [6:0]  sub;
		logic        tick_short;
		logic        tick_long;
	} rtb_tick_state_type;

	function automatic logic [13:0] bcd_to_bin(input logic [15:0] v);
		return 14'(v[15:12]) * 14'h03E8 + 14'(v[11:8]) * 14'h0064
			+ 14'(v[7:4]) * 14'h000A + 14'(v[3:0]);
	endfunction

	function automatic logic [6:0] num_to_bin(input logic [7:0] v);
		return 7'(v[7:4]) * 7'h0A + 7'(v[3:0]);
	endfunction

	function automatic logic bcd_ok(input logic [15:0] v);
		logic ok;
		ok = 1'b1;
		for (int k = 0; k < 4; k++) begin
			if (v[4*k +: 4] > 4'h9)
				ok = 1'b0;
		end
		return ok;
	endfunction

	function automatic rtb_table_type build_defaults();
		rtb_table_type t;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (i < T_CTS) t[i] = DEF_MSD;
			else if (i < T_HANG) t[i] = DEF_CTS;
			else if (i < T_MUTE) t[i] = DEF_HANG;
			else if (i < T_POLL) t[i] = DEF_MUTE;
			else if (i == T_POLL) t[i] = DEF_POLL;
			else if (i < T_IMP) t[i] = DEF_RES;
			else if (i < T_INIT) t[i] = DEF_IMP;
			else if (i < T_PEND) t[i] = DEF_INIT;
			else if (i < T_TOUT) t[i] = DEF_PEND;
			else if (i < T_PTONE) t[i] = DEF_TOUT;
			else if (i < T_PWIN) t[i] = DEF_PTONE;
			else if (i < T_USER) t[i] = DEF_PWIN;
			else t[i] = DEF_USER;
		end
		return t;
	endfunction

	localparam rtb_table_type RESET_TABLE = build_defaults();

endpackage

// *** hdl/rtb_reload_mem.sv ***
module rtb_reload_mem (
	input  wire logic        pclk,    // Controller clock
	input  wire logic        presetn, // Async reset, active low
	input  wire logic [5:0]  raddr,   // Read index
	output logic      [15:0] rdata,   // Registered read data
	input  wire logic        we,      // Write strobe
	input  wire logic [5:0]  waddr,   // Write index
	input  wire logic [15:0] wdata    // Write data, BCD
);

	rtb_pkg::rtb_mem_state_type s;
	rtb_pkg::rtb_mem_state_type next_s;

	always_comb begin
		next_s = s;
		if (we)
			next_s.mem[waddr] = wdata;
		// Write-through so a same-cycle reload sees the new value
		next_s.rdata = (we && waddr == raddr) ? wdata : s.mem[raddr];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s.mem   <= rtb_pkg::RESET_TABLE;
			s.rdata <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;

endmodule

// *** hdl/rtb_tick_gen.sv ***
module rtb_tick_gen #(
	parameter int unsigned SHORT_CYC = rtb_pkg::SHORT_TICK_CYC
) (
	input  wire logic pclk,       // Controller clock
	input  wire logic presetn,    // Async reset, active low
	output logic      tick_short, // One pulse per 10 ms
	output logic      tick_long   // One pulse per second
);

	rtb_pkg::rtb_tick_state_type s;
	rtb_pkg::rtb_tick_state_type next_s;

	always_comb begin
		next_s            = s;
		next_s.tick_short = 1'b0;
		next_s.tick_long  = 1'b0;
		if (s.cnt == 24'(SHORT_CYC - 1)) begin
			next_s.cnt        = '0;
			next_s.tick_short = 1'b1;
			if (s.sub == rtb_pkg::SHORT_PER_LONG - 7'h01) begin
				next_s.sub       = '0;
				next_s.tick_long = 1'b1;
			end else begin
				next_s.sub = s.sub + 7'h01;
			end
		end else begin
			next_s.cnt = s.cnt + 24'h000001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign tick_short = s.tick_short;
	assign tick_long  = s.tick_long;

	property p_long_on_short;
		@(posedge pclk) disable iff (!presetn)
		tick_long |-> tick_short ##1 !tick_short;
	endproperty
	a_long_on_short: assert property (p_long_on_short)
		else $error("second tick not aligned to a 10 ms tick");

endmodule

// *** hdl/rtb_timer_bank.sv ***
// Behaviour
// - Program: two-digit timer, 1-4 digit value
// - Hold tones until start delay after keying
// - Timers 00-02: start delay per transmitter
// - Courtesy beep after delay from unkey
// - Hang keeps key line; zero hangs forever
// - Mute after digit release; zero mutes forever
// - Timer 12 paces input polling strobe
// - Timers 13-25 reserved, never run
// - Impolite ID on expiry or inactivity
// - Initial ID after idle period
// - Pending ID in activity; initial wins
// - Timeout disables receiver until it drops
// - Timeout value zero never disables
// - Long timers count whole seconds
// - Preaccess tone stops on timer, digit, window
// - Window restarts per digit; expiry drops access
// - Window value zero never expires
// - User timers run by command, fire macro
// - Recall reports programmed reload value
// - Short timers tick every 10 ms
// - Restart reloads and runs the timer
// - Cancel stops a running or start-pending timer
module rtb_timer_bank #(
	parameter int unsigned SHORT_TICK_CYC = rtb_pkg::SHORT_TICK_CYC
) (
	input  wire logic                      pclk,    // Controller clock
	input  wire logic                      presetn, // Async reset
	input  wire logic                      psel,    // APB select
	input  wire logic                      penable, // APB enable
	input  wire logic                      pwrite,  // APB direction
	input  wire logic [7:0]                paddr,   // APB byte address
	input  wire logic [31:0]               pwdata,  // APB write data
	output logic      [31:0]               prdata,  // APB read data
	output logic                           pready,  // APB ready
	output logic                           pslverr, // APB error
	input  wire rtb_pkg::rtb_port_in_type  rx_in,   // Receiver lines
	output rtb_pkg::rtb_port_out_type      evt_out  // Port controls
);

	rtb_pkg::rtb_state_type s;
	rtb_pkg::rtb_state_type next_s;
	rtb_pkg::rtb_cmd_type   cmd;
	logic [15:0]            mem_rdata;
	logic                   mem_we;
	logic                   tick_short;
	logic                   tick_long;
	logic [6:0]             cmd_num;
	logic [5:0]             cmd_idx;
	logic                   cmd_valid;
	logic                   cmd_accept;
	logic                   access;
	logic                   mapped;
	logic [2:0]             c_rise;
	logic [2:0]             c_fall;
	logic [2:0]             d_rise;
	logic [2:0]             d_fall;
	logic [2:0]             key_n;
	logic [2:0]             key_rise;
	logic [2:0]             key_fall;

	rtb_reload_mem u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.raddr   (s.scan),
		.rdata   (mem_rdata),
		.we      (mem_we),
		.waddr   (cmd_idx),
		.wdata   (cmd.value)
	);

	rtb_tick_gen #(
		.SHORT_CYC (SHORT_TICK_CYC)
	) u_tick (
		.pclk       (pclk),
		.presetn    (presetn),
		.tick_short (tick_short),
		.tick_long  (tick_long)
	);

	assign cmd     = rtb_pkg::rtb_cmd_type'(pwdata);
	assign cmd_num = rtb_pkg::num_to_bin(cmd.num);
	assign cmd_idx = cmd_num[5:0];
	assign access  = psel & penable;
	assign mapped  = paddr == rtb_pkg::ADDR_CMD || paddr == rtb_pkg::ADDR_RESP
		|| paddr == rtb_pkg::ADDR_STAT || paddr == rtb_pkg::ADDR_RUN_LO
		|| paddr == rtb_pkg::ADDR_RUN_HI;
	assign cmd_accept = access & pwrite & (paddr == rtb_pkg::ADDR_CMD)
		& (s.cstate == rtb_pkg::CMD_IDLE);
	assign cmd_valid = rtb_pkg::bcd_ok({8'h00, cmd.num})
		&& cmd_num <= rtb_pkg::MAX_NUM
		&& (cmd.op == rtb_pkg::OP_RECALL || cmd.op == rtb_pkg::OP_RESTART
		|| cmd.op == rtb_pkg::OP_CANCEL
		|| (cmd.op == rtb_pkg::OP_PROGRAM && rtb_pkg::bcd_ok(cmd.value)));
	assign pready  = 1'b1;
	assign pslverr = access & (!mapped
		| (pwrite & (paddr != rtb_pkg::ADDR_CMD
		| s.cstate != rtb_pkg::CMD_IDLE)));
	assign prdata  = s.prdata;
	assign evt_out = s.out;
	assign c_rise  = rx_in.carrier_detect_input & ~s.prev_carrier;
	assign c_fall  = ~rx_in.carrier_detect_input & s.prev_carrier;
	assign d_rise  = rx_in.digit_active & ~s.prev_digit;
	assign d_fall  = ~rx_in.digit_active & s.prev_digit;

	always_comb begin
		next_s = s;
		mem_we = 1'b0;
		key_n = '0;
		key_rise = '0;
		key_fall = '0;
		next_s.exp = '0;
		next_s.out.courtesy_send = '0;
		next_s.out.timeout_event = '0;
		next_s.out.timeout_clear_event = '0;
		next_s.out.access_lost = '0;
		next_s.out.io_poll_strobe = 1'b0;
		next_s.out.id_impolite = '0;
		next_s.out.id_initial = '0;
		next_s.out.id_pending = '0;
		next_s.out.user_macro = '0;
		next_s.prev_carrier = rx_in.carrier_detect_input;
		next_s.prev_digit = rx_in.digit_active;
		next_s.scan_q = s.scan;
		next_s.scan = (s.scan == 6'(rtb_pkg::T_LAST)) ? '0 : s.scan + 6'h01;

		// One timer serviced per cycle, in scan order
		if (s.start_pend[s.scan_q]) begin
			next_s.count[s.scan_q] = rtb_pkg::bcd_to_bin(mem_rdata);
			next_s.run[s.scan_q] = 1'b1;
			next_s.start_pend[s.scan_q] = 1'b0;
			next_s.tick_pend[s.scan_q] = 1'b0;
		end else if (s.tick_pend[s.scan_q]) begin
			next_s.tick_pend[s.scan_q] = 1'b0;
			// A zero count never runs down
			if (s.run[s.scan_q] && s.count[s.scan_q] == 14'h0001) begin
				next_s.run[s.scan_q] = 1'b0;
				next_s.exp[s.scan_q] = 1'b1;
			end else if (s.run[s.scan_q] && s.count[s.scan_q] != '0) begin
				next_s.count[s.scan_q] = s.count[s.scan_q] - 14'h0001;
			end
		end
		if (tick_short)
			next_s.tick_pend = next_s.tick_pend | rtb_pkg::SHORT_MASK;
		if (tick_long)
			next_s.tick_pend = next_s.tick_pend | rtb_pkg::LONG_MASK;

		for (int i = 0; i < 3; i++) begin
			if (c_fall[i]) begin
				next_s.start_pend[rtb_pkg::T_HANG + i] = 1'b1;
				next_s.start_pend[rtb_pkg::T_CTS + i] = 1'b1;
				next_s.run[rtb_pkg::T_TOUT + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_TOUT + i] = 1'b0;
				if (s.timed_out[i]) begin
					next_s.timed_out[i] = 1'b0;
					next_s.out.timeout_clear_event[i] = 1'b1;
				end
			end
			if (c_rise[i]) begin
				next_s.run[rtb_pkg::T_HANG + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_HANG + i] = 1'b0;
				next_s.run[rtb_pkg::T_CTS + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_CTS + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_TOUT + i] = 1'b1;
			end
			if (s.exp[rtb_pkg::T_CTS + i])
				next_s.cts_pend[i] = 1'b1;
			if (s.exp[rtb_pkg::T_TOUT + i]) begin
				next_s.timed_out[i] = 1'b1;
				next_s.out.timeout_event[i] = 1'b1;
			end
			if (d_fall[i]) begin
				next_s.start_pend[rtb_pkg::T_MUTE + i] = 1'b1;
				next_s.start_pend[rtb_pkg::T_PWIN + i] = 1'b1;
			end
			if (rx_in.preaccess_start[i]) begin
				next_s.start_pend[rtb_pkg::T_PTONE + i] = 1'b1;
				next_s.start_pend[rtb_pkg::T_PWIN + i] = 1'b1;
			end
			if (d_rise[i] || s.exp[rtb_pkg::T_PWIN + i]) begin
				next_s.run[rtb_pkg::T_PTONE + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_PTONE + i] = 1'b0;
			end
			if (s.exp[rtb_pkg::T_PWIN + i])
				next_s.out.access_lost[i] = 1'b1;
		end

		if (s.exp[rtb_pkg::T_POLL]) begin
			next_s.start_pend[rtb_pkg::T_POLL] = 1'b1;
			next_s.out.io_poll_strobe = 1'b1;
		end
		for (int u = 0; u < 5; u++) begin
			if (s.exp[rtb_pkg::T_USER + u])
				next_s.out.user_macro[u] = 1'b1;
		end

		if (cmd_accept) begin
			next_s.resp_valid = 1'b0;
			next_s.err = !cmd_valid;
			next_s.resp.num = cmd.num;
			next_s.resp.sep = rtb_pkg::SEP_ACK;
			next_s.resp.value = '0;
			if (cmd_valid) begin
				if (cmd.op == rtb_pkg::OP_PROGRAM) begin
					mem_we = 1'b1;
					next_s.resp.sep = rtb_pkg::SEP_IS;
					next_s.resp.value = cmd.value;
					next_s.resp_valid = 1'b1;
				end else if (cmd.op == rtb_pkg::OP_RECALL) begin
					next_s.cstate = rtb_pkg::CMD_RECALL;
					next_s.target = cmd_idx;
				end else if (cmd.op == rtb_pkg::OP_RESTART) begin
					if (!rtb_pkg::RES_MASK[cmd_idx])
						next_s.start_pend[cmd_idx] = 1'b1;
					next_s.resp_valid = 1'b1;
				end else begin
					next_s.run[cmd_idx] = 1'b0;
					next_s.start_pend[cmd_idx] = 1'b0;
					next_s.resp_valid = 1'b1;
				end
			end
		end

		unique case (s.cstate)
			rtb_pkg::CMD_IDLE: begin
			end
			rtb_pkg::CMD_RECALL: begin
				if (s.scan_q == s.target) begin
					next_s.resp.sep = rtb_pkg::SEP_IS;
					next_s.resp.value = mem_rdata;
					next_s.resp_valid = 1'b1;
					next_s.cstate = rtb_pkg::CMD_IDLE;
				end
			end
		endcase

		for (int i = 0; i < 3; i++) begin
			key_n[i] = rx_in.carrier_detect_input[i]
				| next_s.run[rtb_pkg::T_HANG + i]
				| next_s.start_pend[rtb_pkg::T_HANG + i];
			key_rise[i] = key_n[i] & ~s.out.transmitter_key_line[i];
			key_fall[i] = ~key_n[i] & s.out.transmitter_key_line[i];
			if (s.exp[rtb_pkg::T_MSD + i])
				next_s.msd_done[i] = 1'b1;
			if (key_rise[i]) begin
				next_s.msd_done[i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_MSD + i] = 1'b1;
			end
			if (key_fall[i]) begin
				next_s.run[rtb_pkg::T_MSD + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_MSD + i] = 1'b0;
			end
			next_s.out.transmitter_key_line[i] = key_n[i];
			next_s.out.tone_hold[i] = key_n[i] & ~next_s.msd_done[i];
			if (s.cts_pend[i] && !next_s.out.tone_hold[i]
				&& !s.exp[rtb_pkg::T_CTS + i]) begin
				next_s.cts_pend[i] = 1'b0;
				next_s.out.courtesy_send[i] = 1'b1;
			end
			next_s.out.rx_mute[i] = rx_in.digit_active[i]
				| next_s.run[rtb_pkg::T_MUTE + i]
				| next_s.start_pend[rtb_pkg::T_MUTE + i];
			next_s.out.rx_disabled[i] = next_s.timed_out[i];
			next_s.out.preaccess_tone[i] = next_s.run[rtb_pkg::T_PTONE + i]
				| next_s.start_pend[rtb_pkg::T_PTONE + i];
		end

		for (int i = 0; i < 2; i++) begin
			if (key_rise[i]) begin
				next_s.start_pend[rtb_pkg::T_IMP + i] = 1'b1;
				next_s.start_pend[rtb_pkg::T_PEND + i] = 1'b1;
				next_s.run[rtb_pkg::T_INIT + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_INIT + i] = 1'b0;
			end
			if (key_fall[i]) begin
				next_s.start_pend[rtb_pkg::T_INIT + i] = 1'b1;
				if (s.run[rtb_pkg::T_IMP + i])
					next_s.out.id_impolite[i] = 1'b1;
				next_s.run[rtb_pkg::T_IMP + i] = 1'b0;
				next_s.start_pend[rtb_pkg::T_IMP + i] = 1'b0;
			end
			if (s.exp[rtb_pkg::T_IMP + i])
				next_s.out.id_impolite[i] = 1'b1;
			if (s.exp[rtb_pkg::T_INIT + i])
				next_s.out.id_initial[i] = 1'b1;
			if (s.exp[rtb_pkg::T_PEND + i] && !s.exp[rtb_pkg::T_INIT + i])
				next_s.out.id_pending[i] = 1'b1;
		end

		next_s.prdata = '0;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				rtb_pkg::ADDR_RESP: next_s.prdata = s.resp;
				rtb_pkg::ADDR_STAT: begin
					next_s.prdata[rtb_pkg::STAT_VALID] = s.resp_valid;
					next_s.prdata[rtb_pkg::STAT_BUSY] =
						s.cstate == rtb_pkg::CMD_RECALL;
					next_s.prdata[rtb_pkg::STAT_ERR] = s.err;
				end
				rtb_pkg::ADDR_RUN_LO: next_s.prdata = s.run[31:0];
				rtb_pkg::ADDR_RUN_HI: next_s.prdata = 32'(s.run[45:32]);
				default: next_s.prdata = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s            <= '0;
			s.cstate     <= rtb_pkg::CMD_IDLE;
			s.start_pend <= rtb_pkg::POLL_MASK;
		end else begin
			s <= next_s;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_digit_release;
		$fell(rx_in.digit_active[0]);
	endsequence
	property p_mute_after_digit;
		s_digit_release |=> evt_out.rx_mute[0] [*2];
	endproperty
	a_mute_after_digit: assert property (p_mute_after_digit)
		else $error("receiver not muted after digit release");

	property p_hang_holds;
		$fell(rx_in.carrier_detect_input[0])
			|=> evt_out.transmitter_key_line[0];
	endproperty
	a_hang_holds: assert property (p_hang_holds)
		else $error("key line dropped at receiver release");

	property p_tone_held_at_key;
		$rose(evt_out.transmitter_key_line[0]) |-> evt_out.tone_hold[0];
	endproperty
	a_tone_held_at_key: assert property (p_tone_held_at_key)
		else $error("tones allowed right at keying");

	property p_timeout_clear;
		($fell(rx_in.carrier_detect_input[0]) && evt_out.rx_disabled[0])
			|=> !evt_out.rx_disabled[0] && evt_out.timeout_clear_event[0];
	endproperty
	a_timeout_clear: assert property (p_timeout_clear)
		else $error("timed out receiver not cleared on release");

	property p_reserved_idle;
		(s.run & rtb_pkg::RES_MASK) == '0;
	endproperty
	a_reserved_idle: assert property (p_reserved_idle)
		else $error("reserved timer running");

	property p_program_ack;
		(cmd_accept && cmd_valid && cmd.op == rtb_pkg::OP_PROGRAM)
			|=> s.resp_valid && s.resp.sep == rtb_pkg::SEP_IS
			&& s.resp.value == $past(pwdata[15:0]);
	endproperty
	a_program_ack: assert property (p_program_ack)
		else $error("program answer wrong");

	property p_recall_done;
		$rose(s.cstate == rtb_pkg::CMD_RECALL)
			|-> ##[1:48] (s.cstate == rtb_pkg::CMD_IDLE && s.resp_valid);
	endproperty
	a_recall_done: assert property (p_recall_done)
		else $error("recall answer late");

	property p_cancel_stops;
		(cmd_accept && cmd_valid && cmd.op == rtb_pkg::OP_CANCEL)
			|=> !s.run[$past(cmd_idx)];
	endproperty
	a_cancel_stops: assert property (p_cancel_stops)
		else $error("cancelled timer still running");

	property p_access_lost_tone;
		evt_out.access_lost[0] |-> !evt_out.preaccess_tone[0];
	endproperty
	a_access_lost_tone: assert property (p_access_lost_tone)
		else $error("preaccess tone outlives window");

	property p_user_macro;
		evt_out.user_macro[0] |-> $past(s.exp[rtb_pkg::T_USER]);
	endproperty
	a_user_macro: assert property (p_user_macro)
		else $error("user macro without expiry");

endmodule

// *** bench/rtb_radio_model.sv ***
module rtb_radio_model (
	input  wire logic                 pclk,  // Controller clock
	input  wire logic [2:0]           talk,  // Receivers keyed
	input  wire logic [2:0]           digit, // Tone digit held
	input  wire logic [2:0]           acc,   // Access code pulse
	output rtb_pkg::rtb_port_in_type  rx_in  // Lines to bank
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge pclk) begin
		rx_in.carrier_detect_input <= talk;
		rx_in.digit_active         <= digit;
		rx_in.preaccess_start      <= acc;
	end
endmodule

// *** bench/rtb_timer_bank_tb.sv ***
module rtb_timer_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] talk, digit, acc;
	logic [15:0] rv;
	rtb_pkg::rtb_port_in_type rx_in;
	rtb_pkg::rtb_port_out_type evt_out;
	logic [32:0] expq[$];
	int n_errors = 0, total_checks = 0, cyc = 0;
	// Tick period above the 46-cycle scan so no tick is merged
	rtb_timer_bank #(.SHORT_TICK_CYC(50)) i_dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_in(rx_in),
		.evt_out(evt_out));
	rtb_radio_model i_rad (.pclk(pclk), .talk(talk), .digit(digit),
		.acc(acc), .rx_in(rx_in));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task chk(input string s, input logic [32:0] e, input logic [32:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		expq.push_back(e);
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task cmd(input logic [3:0] op, input logic [7:0] n, input logic [15:0] v);
		apb(1, 8'h00, {op, n, 4'h0, v}, 33'h0);
	endtask
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1)
			chk("apb", expq.pop_front(), {pslverr, prdata});
	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, talk, digit} = '0;
		acc = '0;
		void'($urandom(32'h4134));
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		// Default start delay, then refused write while busy
		cmd(4'h2, 8'h00, 16'h0);
		apb(1, 8'h00, 32'h0, 33'h1_0000_0000);
		repeat (60) @(posedge pclk);
		apb(0, 8'h04, 0, {1'b0, 8'h00, 8'hA5, 16'h0050});
		$display("test recall done");
		rv = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10),
			4'h7};
		cmd(4'h1, 8'h41, rv);
		apb(0, 8'h08, 0, 33'h1);
		apb(0, 8'h04, 0, {1'b0, 8'h41, 8'hA5, rv});
		cmd(4'h1, 8'h46, 16'h0001);
		apb(0, 8'h08, 0, 33'h4);
		apb(0, 8'h14, 0, 33'h1_0000_0000);
		$display("test program done");
		cmd(4'h3, 8'h41, 16'h0);
		repeat (50) @(posedge pclk);
		apb(0, 8'h10, 0, 33'h200);
		cmd(4'h4, 8'h41, 16'h0);
		repeat (50) @(posedge pclk);
		apb(0, 8'h10, 0, 33'h0);
		cmd(4'h3, 8'h15, 16'h0);
		repeat (50) @(posedge pclk);
		apb(0, 8'h0C, 0, 33'h1000);
		$display("test run control done");
		cmd(4'h1, 8'h06, 16'h0005);
		talk <= 3'h1;
		repeat (10) @(posedge pclk);
		chk("hold", 33'h1, 33'(evt_out.tone_hold));
		talk <= 3'h0;
		repeat (4) @(posedge pclk);
		chk("key", 33'h1, 33'(evt_out.transmitter_key_line));
		repeat (400) @(posedge pclk);
		chk("key", 33'h0, 33'(evt_out.transmitter_key_line));
		$display("test hang done");
		acc <= 3'h1;
		@(posedge pclk);
		acc <= 3'h0;
		repeat (60) @(posedge pclk);
		chk("tone", 33'h1, 33'(evt_out.preaccess_tone));
		digit <= 3'h1;
		repeat (4) @(posedge pclk);
		chk("tone", 33'h0, 33'(evt_out.preaccess_tone));
		digit <= 3'h0;
		repeat (30) @(posedge pclk);
		chk("mute", 33'h1, 33'(evt_out.rx_mute));
		$display("test preaccess done");
		tally_and_finish();
	end
endmodule
